// *** core/tccu_top.sv ***
`timescale 1ns/1ps
`default_nettype none
module tccu_top
    import tccu_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire tccu_pins_s pins,
    input wire logic cpu_irq_mask,
    output logic [1:0] compare_output_pin,
    output logic [1:0] compare_pin_enable,
    output logic timer_irq
);
    ////////////////////////////////////////////////////////////////////
    // bus decode
    logic acc, wr, rd;
    assign acc = psel & penable;
    assign wr = acc & pwrite;
    assign rd = acc & ~pwrite;
    function automatic logic hit(input logic [7:0] a, input logic [7:0] o);
        return a == o;
    endfunction

    logic [7:0] timer_control_one_q, timer_control_two_q;
    logic [15:0] capture_value_q [2];
    logic [15:0] compare_value_q [2];
    logic [15:0] count_q;
    logic [1:0] capture_flag_q, compare_flag_q;
    logic [1:0] cap_armed_q, cmp_armed_q; // status seen with flag set
    logic [1:0] cap_hold_q, cmp_hold_q;
    logic [1:0] sync1_q, sync2_q, prev_q;
    logic ext1_q, ext2_q, extp_q;
    logic [2:0] pre_q;
    logic tick, one_pulse, pwm_mode, special;
    logic [1:0] timer_clock_select;
    assign timer_clock_select = timer_control_two_q[C2_CLK_LO +: 2];
    assign pwm_mode = timer_control_two_q[C2_PWM];
    assign one_pulse = timer_control_two_q[C2_ONE_PULSE] & ~pwm_mode;
    assign special = one_pulse | pwm_mode;

    ////////////////////////////////////////////////////////////////////
    // pin synchronisers, first stage read only by second
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 2'h0;
            sync2_q <= 2'h0;
            prev_q <= 2'h0;
            ext1_q <= 1'h0;
            ext2_q <= 1'h0;
            extp_q <= 1'h0;
        end else begin
            sync1_q <= pins.cap_pin;
            sync2_q <= sync1_q;
            prev_q <= sync2_q;
            ext1_q <= pins.ext_clk;
            ext2_q <= ext1_q;
            extp_q <= ext2_q;
        end
    end

    // external edge select shares the counter clock choice
    logic ext_edge;
    assign ext_edge = timer_control_two_q[C2_EXT_EDGE] ?
        (ext2_q & ~extp_q) : (~ext2_q & extp_q);

    // prescaler tick
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pre_q <= 3'h0;
        end else begin
            pre_q <= pre_q + 3'h1;
        end
    end
    always_comb begin
        unique case (timer_clock_select)
            CLK_DIV2: tick = pre_q[0];
            CLK_DIV4: tick = &pre_q[1:0];
            CLK_DIV8: tick = &pre_q;
            CLK_EXT: tick = ext_edge;
        endcase
    end

    // capture edge detection per channel
    logic [1:0] cap_edge, cap_evt, edge_sel;
    assign edge_sel = {timer_control_two_q[C2_EDGE2],
                       timer_control_one_q[C1_EDGE1]};
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            cap_edge[i] = edge_sel[i] ? (sync2_q[i] & ~prev_q[i])
                                      : (~sync2_q[i] & prev_q[i]);
        end
    end
    // channel one capture is lost to the special modes
    assign cap_evt = cap_edge & ~cap_hold_q & {1'b1, ~special};

    // one pulse start: channel one edge restarts the counter
    logic op_start;
    assign op_start = one_pulse & cap_edge[0];

    ////////////////////////////////////////////////////////////////////
    // free-running counter
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            count_q <= COUNTER_RELOAD;
        end else if (op_start || (wr && hit(paddr, CNT_LO_OFS))) begin
            count_q <= COUNTER_RELOAD;
        end else if (tick) begin
            count_q <= count_q + 16'h0001;
        end
    end

    // capture registers, latched on edge, software cannot write
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_value_q[0] <= 16'h0000;
            capture_value_q[1] <= 16'h0000;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (cap_evt[i]) begin
                    capture_value_q[i] <= count_q;
                end
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // compare match; slow clocks see the match one count late
    logic [1:0] match;
    logic [15:0] target [2];
    always_comb begin
        for (int i = 0; i < 2; i++) begin
            target[i] = (timer_clock_select == CLK_DIV2) ? compare_value_q[i]
                      : compare_value_q[i] + 16'h0001;
            match[i] = tick && !cmp_hold_q[i]
                       && count_q == target[i];
        end
    end
    // flags are not raised on channel one in one pulse, nor at all in pwm
    logic [1:0] cmp_set;
    assign cmp_set = match & {~pwm_mode, ~special};

    ////////////////////////////////////////////////////////////////////
    // byte access strobes per channel
    logic [1:0] cap_lo_acc, cap_hi_rd, cmp_lo_acc, cmp_lo_wr, cmp_hi_wr;
    logic st_rd;
    assign st_rd = rd & hit(paddr, STATUS_OFS);
    assign cap_lo_acc = {acc & hit(paddr, CAP2_LO_OFS),
                         acc & hit(paddr, CAP1_LO_OFS)};
    assign cap_hi_rd = {rd & hit(paddr, CAP2_HI_OFS),
                        rd & hit(paddr, CAP1_HI_OFS)};
    assign cmp_lo_acc = {acc & hit(paddr, CMP2_LO_OFS),
                         acc & hit(paddr, CMP1_LO_OFS)};
    assign cmp_lo_wr = cmp_lo_acc & {2{pwrite}};
    assign cmp_hi_wr = {wr & hit(paddr, CMP2_HI_OFS),
                        wr & hit(paddr, CMP1_HI_OFS)};

    // capture flag and hold; a new event beats a clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            capture_flag_q <= 2'h0;
            cap_armed_q <= 2'h0;
            cap_hold_q <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (cap_evt[i]) begin
                    capture_flag_q[i] <= 1'b1;
                end else if (cap_armed_q[i] && cap_lo_acc[i]) begin
                    capture_flag_q[i] <= 1'b0;
                end
                if (cap_lo_acc[i]) begin
                    cap_armed_q[i] <= 1'b0;
                end else if (st_rd && capture_flag_q[i]) begin
                    cap_armed_q[i] <= 1'b1;
                end
                if (cap_hi_rd[i]) begin
                    cap_hold_q[i] <= 1'b1;
                end else if (cap_lo_acc[i] && !pwrite) begin
                    cap_hold_q[i] <= 1'b0;
                end
            end
        end
    end

    // compare flag and hold
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_flag_q <= 2'h0;
            cmp_armed_q <= 2'h0;
            cmp_hold_q <= 2'h0;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (cmp_set[i]) begin
                    compare_flag_q[i] <= 1'b1;
                end else if (cmp_lo_wr[i]
                             || (cmp_armed_q[i] && cmp_lo_acc[i])) begin
                    compare_flag_q[i] <= 1'b0;
                end
                if (cmp_lo_acc[i]) begin
                    cmp_armed_q[i] <= 1'b0;
                end else if (st_rd && compare_flag_q[i]) begin
                    cmp_armed_q[i] <= 1'b1;
                end
                if (cmp_hi_wr[i]) begin
                    cmp_hold_q[i] <= 1'b1;
                end else if (cmp_lo_wr[i]) begin
                    cmp_hold_q[i] <= 1'b0;
                end
            end
        end
    end

    // compare registers, only software writes them
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_value_q[0] <= COMPARE_RESET;
            compare_value_q[1] <= COMPARE_RESET;
        end else begin
            for (int i = 0; i < 2; i++) begin
                if (cmp_hi_wr[i]) begin
                    compare_value_q[i][15:8] <= pwdata[7:0];
                end
                if (cmp_lo_wr[i]) begin
                    compare_value_q[i][7:0] <= pwdata[7:0];
                end
            end
        end
    end

    // control registers
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_control_one_q <= 8'h00;
            timer_control_two_q <= 8'h00;
        end else begin
            if (wr && hit(paddr, CTRL1_OFS)) begin
                timer_control_one_q <= pwdata[7:0];
            end
            if (wr && hit(paddr, CTRL2_OFS)) begin
                timer_control_two_q <= pwdata[7:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////
    // output latches; force bits act on their write only
    logic [1:0] lvl, force_wr, lvl_wr;
    assign lvl = {timer_control_one_q[C1_LVL2], timer_control_one_q[C1_LVL1]};
    // a forced pin takes the level being written, not the stale one
    assign lvl_wr = {pwdata[C1_LVL2], pwdata[C1_LVL1]};
    assign force_wr = {2{wr && hit(paddr, CTRL1_OFS) && !special}}
                    & {pwdata[C1_FORCE2], pwdata[C1_FORCE1]};
    logic [1:0] pin_en;
    assign pin_en = {timer_control_two_q[C2_PIN_EN2],
                     timer_control_two_q[C2_PIN_EN1]};
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            compare_output_pin <= 2'h0;
            compare_pin_enable <= 2'h0;
        end else begin
            compare_pin_enable <= pin_en;
            for (int i = 0; i < 2; i++) begin
                if (force_wr[i]) begin
                    compare_output_pin[i] <= lvl_wr[i];
                end else if (i == 0 && op_start) begin
                    compare_output_pin[i] <= lvl[1];
                end else if (match[i] && pin_en[i]
                             && !(i == 1 && special)) begin
                    compare_output_pin[i] <= lvl[i];
                end
            end
        end
    end

    // one interrupt line; pending until mask clears
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            timer_irq <= 1'b0;
        end else begin
            timer_irq <= !cpu_irq_mask
                && ((timer_control_one_q[C1_CAP_IE] && |capture_flag_q)
                 || (timer_control_one_q[C1_CMP_IE] && |compare_flag_q));
        end
    end

    ////////////////////////////////////////////////////////////////////
    // apb read data, one wait-free access
    logic [7:0] rsel;
    always_comb begin
        rsel = 8'h00;
        unique case (paddr)
            CTRL1_OFS: rsel = timer_control_one_q;
            CTRL2_OFS: rsel = timer_control_two_q;
            STATUS_OFS: begin
                rsel[ST_CAP1] = capture_flag_q[0];
                rsel[ST_CMP1] = compare_flag_q[0];
                rsel[ST_CAP2] = capture_flag_q[1];
                rsel[ST_CMP2] = compare_flag_q[1];
            end
            CAP1_HI_OFS: rsel = capture_value_q[0][15:8];
            CAP1_LO_OFS: rsel = capture_value_q[0][7:0];
            CAP2_HI_OFS: rsel = capture_value_q[1][15:8];
            CAP2_LO_OFS: rsel = capture_value_q[1][7:0];
            CMP1_HI_OFS: rsel = compare_value_q[0][15:8];
            CMP1_LO_OFS: rsel = compare_value_q[0][7:0];
            CMP2_HI_OFS: rsel = compare_value_q[1][15:8];
            CMP2_LO_OFS: rsel = compare_value_q[1][7:0];
            CNT_HI_OFS: rsel = count_q[15:8];
            CNT_LO_OFS: rsel = count_q[7:0];
            default: rsel = 8'h00;
        endcase
    end
    logic mapped;
    assign mapped = paddr <= CNT_LO_OFS && paddr[1:0] == 2'h0;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pready <= 1'b0;
            pslverr <= 1'b0;
        end else begin
            pready <= psel & ~penable;
            pslverr <= psel & ~penable & ~mapped;
            prdata <= {24'h000000, rsel};
        end
    end
endmodule
`default_nettype wire

// *** core/tccu_pkg.sv ***
// Function
// - two capture registers latch counter on edge
// - capture registers are read only
// - edge select bit picks rising or falling
// - one capture irq enable for both pins
// - capture sets flag, irq when enabled, unmasked
// - status read then low byte access clears
// - high byte read blocks capture until low
// - capture register keeps most recent value
// - special modes leave only capture two
// - the selected pin edge captures unless inhibited
// - match sets flag, drives level, requests irq
// - compare registers software only, reset 8000h
// - compare pin latch low during reset
// - status read then low compare access clears
// - high compare write suspends matching
// - low compare write re-enables, clears flag
// - pin disabled: no level, flag still set
// - match at value, or value plus one
// - force bit copies level, no flag
// - force bits ignored in special modes
// - mode bit selects one pulse mode
// - counter resets and reloads to FFFCh
// - clock select code three picks external clock
package tccu_pkg;
    localparam logic [7:0] CTRL1_OFS = 8'h00;
    localparam logic [7:0] CTRL2_OFS = 8'h04;
    localparam logic [7:0] STATUS_OFS = 8'h08;
    localparam logic [7:0] CAP1_HI_OFS = 8'h0C;
    localparam logic [7:0] CAP1_LO_OFS = 8'h10;
    localparam logic [7:0] CAP2_HI_OFS = 8'h14;
    localparam logic [7:0] CAP2_LO_OFS = 8'h18;
    localparam logic [7:0] CMP1_HI_OFS = 8'h1C;
    localparam logic [7:0] CMP1_LO_OFS = 8'h20;
    localparam logic [7:0] CMP2_HI_OFS = 8'h24;
    localparam logic [7:0] CMP2_LO_OFS = 8'h28;
    localparam logic [7:0] CNT_HI_OFS = 8'h2C;
    localparam logic [7:0] CNT_LO_OFS = 8'h30;
    localparam logic [15:0] COMPARE_RESET = 16'h8000;
    localparam logic [15:0] COUNTER_RELOAD = 16'hFFFC;
    localparam logic [1:0] CLK_DIV2 = 2'h0;
    localparam logic [1:0] CLK_DIV4 = 2'h1;
    localparam logic [1:0] CLK_DIV8 = 2'h2;
    localparam logic [1:0] CLK_EXT = 2'h3;
    // control one fields
    localparam int C1_CAP_IE = 7;
    localparam int C1_CMP_IE = 6;
    localparam int C1_EDGE1 = 1;
    localparam int C1_LVL1 = 0;
    localparam int C1_LVL2 = 2;
    localparam int C1_FORCE1 = 3;
    localparam int C1_FORCE2 = 4;
    // control two fields
    localparam int C2_PIN_EN1 = 7;
    localparam int C2_PIN_EN2 = 6;
    localparam int C2_ONE_PULSE = 5;
    localparam int C2_PWM = 4;
    localparam int C2_CLK_LO = 2;
    localparam int C2_EDGE2 = 1;
    localparam int C2_EXT_EDGE = 0;
    // status fields
    localparam int ST_CAP1 = 7;
    localparam int ST_CMP1 = 6;
    localparam int ST_CAP2 = 4;
    localparam int ST_CMP2 = 3;
    typedef struct packed {
        logic [1:0] cap_pin;
        logic ext_clk;
    } tccu_pins_s;
endpackage

// *** tb/tccu_properties.sv ***
`timescale 1ns/1ps
`default_nettype none
module tccu_properties
    import tccu_pkg::*;
(
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire tccu_pins_s pins,
    input wire logic cpu_irq_mask,
    input wire logic [1:0] compare_output_pin,
    input wire logic [1:0] compare_pin_enable,
    input wire logic timer_irq
);
    logic acc;
    logic [7:0] c1_q;
    logic [7:0] c2_q;
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////////////////
    // shadows of the control bytes, taken at completed writes
    assign acc = psel && penable && pready && pwrite;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            c1_q <= 8'h00;
            c2_q <= 8'h00;
        end else if (acc && paddr == CTRL1_OFS) begin
            c1_q <= pwdata[7:0];
        end else if (acc && paddr == CTRL2_OFS) begin
            c2_q <= pwdata[7:0];
        end
    end
    ////////////////////////////////////////////////////////////////////////
    a_ready_after_setup: assert property (
        psel && !penable |=> pready) else $error("no pready in access");
    a_err_unmapped: assert property (
        pslverr |-> pready && (paddr > CNT_LO_OFS || paddr[1:0] != 2'h0))
        else $error("bad pslverr");
    a_unmapped_zero: assert property (
        pready && paddr > CNT_LO_OFS |-> pslverr && prdata == 32'h0)
        else $error("unmapped access not refused");
    a_read_upper_zero: assert property (
        pready && !pwrite |-> prdata[31:8] == 24'h0)
        else $error("upper read data not zero");
    a_pin_en_copy: assert property (
        acc && paddr == CTRL2_OFS |-> ##[1:2]
        compare_pin_enable == {c2_q[C2_PIN_EN2], c2_q[C2_PIN_EN1]})
        else $error("pin enable not copied");
    // force only counts with the pin driven and no special mode
    a_force_copy: assert property (
        acc && paddr == CTRL1_OFS && pwdata[C1_FORCE1] && c2_q[C2_PIN_EN1]
        && !c2_q[C2_ONE_PULSE] && !c2_q[C2_PWM]
        |-> ##[1:2] compare_output_pin[0] == c1_q[C1_LVL1])
        else $error("forced level not on pin");
    a_mask_blocks: assert property (
        cpu_irq_mask && $past(cpu_irq_mask) |-> !timer_irq)
        else $error("irq while masked");
    a_irq_needs_en: assert property (
        !c1_q[C1_CAP_IE] && !c1_q[C1_CMP_IE] && !$past(c1_q[C1_CAP_IE])
        && !$past(c1_q[C1_CMP_IE]) |-> !timer_irq)
        else $error("irq without enable");
    a_pins_low_reset: assert property (
        $rose(presetn) |-> compare_output_pin == 2'h0)
        else $error("compare pins not low out of reset");
endmodule
bind tccu_top tccu_properties i_tccu_properties (.pclk(pclk),
    .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .pins(pins), .cpu_irq_mask(cpu_irq_mask),
    .compare_output_pin(compare_output_pin),
    .compare_pin_enable(compare_pin_enable), .timer_irq(timer_irq));
`default_nettype wire

// *** tb/tccu_top_tb_top.sv ***
`timescale 1ns/1ps
`default_nettype none
`define CHK(g, e) begin \
    comparisons++; \
    if ((g) !== (e)) begin \
        error_cnt++; \
        $display("Error at %0t: got %0h exp %0h", $time, g, e); \
    end \
end
module tccu_top_tb_top
    import tccu_pkg::*;
();
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    tccu_pins_s pins = '0;
    logic cpu_irq_mask = 1'b1;
    logic [1:0] compare_output_pin;
    logic [1:0] compare_pin_enable;
    logic timer_irq;
    logic [31:0] q;
    logic err_q;
    logic [7:0] v;
    int error_cnt = 0;
    int comparisons = 0;
    int cycles = 0;
    tccu_top i_tccu_top (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr),
        .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .pins(pins), .cpu_irq_mask(cpu_irq_mask),
        .compare_output_pin(compare_output_pin),
        .compare_pin_enable(compare_pin_enable), .timer_irq(timer_irq));
    always #25 pclk = ~pclk;
    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("comparisons %0d, mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    // hang guard, the sequence needs only about 1300 cycles
    always @(posedge pclk) begin
        cycles++;
        if (cycles == 20000) begin
            error_cnt++;
            wrap_up();
        end
    end
    // one apb transfer; request held until pready is seen at an edge
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= {24'h000000, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        err_q = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rd(input logic [7:0] a, input logic [7:0] e,
        input logic [7:0] m);
        apb(1'b0, a, 8'h00);
        `CHK(q[7:0] & m, e & m)
    endtask
    // pin change, then room for the three cycle synchroniser
    task automatic tog(input int ch, input logic lvl);
        @(posedge pclk);
        pins.cap_pin[ch] <= lvl;
        repeat (6) @(posedge pclk);
    endtask
    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        rd(CMP1_HI_OFS, 8'h80, 8'hFF);
        rd(CMP2_LO_OFS, 8'h00, 8'hFF);
        `CHK(compare_output_pin, 2'h0)
        rd(8'hFC, 8'h00, 8'hFF);
        `CHK(err_q, 1'b1)
        wr(CMP2_HI_OFS, 8'h12);
        wr(CMP2_LO_OFS, 8'h34);
        rd(CMP2_HI_OFS, 8'h12, 8'hFF);
        rd(CMP2_LO_OFS, 8'h34, 8'hFF);
        rd(CAP1_HI_OFS, 8'h00, 8'h00);
        v = q[7:0];
        wr(CAP1_HI_OFS, ~v);
        rd(CAP1_HI_OFS, v, 8'hFF);
        rd(CAP1_LO_OFS, 8'h00, 8'h00);
        // capture right after a reload lands on FFFC..FFFF
        wr(CTRL1_OFS, 8'h02);
        wr(CNT_LO_OFS, 8'h00);
        tog(0, 1'b1);
        rd(STATUS_OFS, 8'h80, 8'h90);
        rd(CAP1_HI_OFS, 8'hFF, 8'hFF);
        rd(CAP1_LO_OFS, 8'hF8, 8'hF8);
        rd(STATUS_OFS, 8'h00, 8'h80);
        tog(0, 1'b0);
        rd(STATUS_OFS, 8'h00, 8'h80);
        rd(CAP1_HI_OFS, 8'h00, 8'h00);
        tog(0, 1'b1);
        rd(STATUS_OFS, 8'h00, 8'h80);
        rd(CAP1_LO_OFS, 8'h00, 8'h00);
        tog(0, 1'b0);
        tog(0, 1'b1);
        rd(STATUS_OFS, 8'h80, 8'h80);
        tog(1, 1'b1);
        rd(STATUS_OFS, 8'h80, 8'h90);
        tog(1, 1'b0);
        rd(STATUS_OFS, 8'h90, 8'h90);
        rd(CAP1_LO_OFS, 8'h00, 8'h00);
        rd(CAP2_LO_OFS, 8'h00, 8'h00);
        rd(STATUS_OFS, 8'h00, 8'h90);
        // a late capture overwrites; irq waits for the mask
        wr(CTRL1_OFS, 8'h82);
        wr(CNT_LO_OFS, 8'h00);
        repeat (700) @(posedge pclk);
        tog(0, 1'b0);
        tog(0, 1'b1);
        `CHK(timer_irq, 1'b0)
        cpu_irq_mask <= 1'b0;
        repeat (3) @(posedge pclk);
        `CHK(timer_irq, 1'b1)
        rd(STATUS_OFS, 8'h80, 8'h80);
        rd(CAP1_HI_OFS, 8'h01, 8'hFF);
        rd(CAP1_LO_OFS, 8'h00, 8'h00);
        repeat (3) @(posedge pclk);
        `CHK(timer_irq, 1'b0)
        // compare with the high byte write suspending the match at 0000
        wr(CTRL1_OFS, 8'h41);
        wr(CTRL2_OFS, 8'h80);
        wr(CNT_LO_OFS, 8'h00);
        `CHK(compare_pin_enable, 2'h1)
        wr(CMP1_HI_OFS, 8'h00);
        repeat (30) @(posedge pclk);
        rd(STATUS_OFS, 8'h00, 8'h40);
        wr(CMP1_LO_OFS, 8'h20);
        repeat (100) @(posedge pclk);
        `CHK(compare_output_pin[0], 1'b1)
        `CHK(timer_irq, 1'b1)
        rd(STATUS_OFS, 8'h40, 8'h40);
        rd(CMP1_LO_OFS, 8'h20, 8'hFF);
        rd(STATUS_OFS, 8'h00, 8'h40);
        wr(CTRL1_OFS, 8'h08);
        repeat (3) @(posedge pclk);
        `CHK(compare_output_pin[0], 1'b0)
        rd(STATUS_OFS, 8'h00, 8'h40);
        // pin disabled: flag without level
        wr(CTRL1_OFS, 8'h41);
        wr(CTRL2_OFS, 8'h00);
        wr(CNT_LO_OFS, 8'h00);
        wr(CMP1_LO_OFS, 8'h10);
        repeat (60) @(posedge pclk);
        rd(STATUS_OFS, 8'h40, 8'h40);
        `CHK(compare_output_pin[0], 1'b0)
        wr(CMP1_LO_OFS, 8'h10);
        rd(STATUS_OFS, 8'h00, 8'h40);
        // external clock: counter steps only on its edges, match one late
        wr(CTRL2_OFS, 8'h0D);
        wr(CMP2_HI_OFS, 8'hFF);
        wr(CMP2_LO_OFS, 8'hFE);
        wr(CNT_LO_OFS, 8'h00);
        repeat (3) begin
            pins.ext_clk <= 1'b1;
            repeat (4) @(posedge pclk);
            pins.ext_clk <= 1'b0;
            repeat (4) @(posedge pclk);
        end
        rd(CNT_LO_OFS, 8'hFF, 8'hFF);
        rd(STATUS_OFS, 8'h00, 8'h08);
        pins.ext_clk <= 1'b1;
        repeat (6) @(posedge pclk);
        pins.ext_clk <= 1'b0;
        rd(STATUS_OFS, 8'h08, 8'h08);
        // one pulse: force ignored, edge starts the pulse
        wr(CTRL2_OFS, 8'hA0);
        wr(CTRL1_OFS, 8'h09);
        repeat (3) @(posedge pclk);
        `CHK(compare_output_pin[0], 1'b0)
        wr(CTRL1_OFS, 8'h06);
        tog(0, 1'b0);
        tog(0, 1'b1);
        `CHK(compare_output_pin[0], 1'b1)
        repeat (60) @(posedge pclk);
        `CHK(compare_output_pin[0], 1'b0)
        rd(STATUS_OFS, 8'h00, 8'h80);
        tog(1, 1'b1);
        tog(1, 1'b0);
        rd(STATUS_OFS, 8'h10, 8'h90);
        wrap_up();
    end
endmodule
`default_nettype wire
